/* File: src/tsc_defs.svh */
// constants for the time-slice coincidence block: periods, counts, field positions, encodings
// assumes inclusion by bare name from every design file that needs them
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// slice period in system clocks for each event-word mode
`define TSC_PERIOD_SHORT   4'h8
`define TSC_PERIOD_LONG    5'h10
`define TSC_LAST_SHORT     4'h7
`define TSC_LAST_LONG      4'hf

// input links and per-slice limits
`define TSC_LINKS          8
`define TSC_WORDS_PER_LINK 3'h4
`define TSC_SLICE_WORDS    6'h20
`define TSC_PAIR_LIMIT     5'h10
`define TSC_PAIRS          28

// singles word: full width in long mode, half width in short mode
`define TSC_WORD_W         32
`define TSC_SHORT_MASK     32'h0000ffff

// source fields inside a singles word
`define TSC_BOARD_LSB      0
`define TSC_UNIT_LSB       3

// system size selection
`define TSC_CFG_SINGLE     2'h0
`define TSC_CFG_MID        2'h1
`define TSC_CFG_LARGE      2'h2

// slice buffer: two banks of one slice each
`define TSC_RAM_DEPTH      64

`endif

/* File: src/tsc_pkg.sv */
// types shared by the time-slice coincidence modules
// assumes tsc_defs.svh is reachable on the include path
`include "tsc_defs.svh"

package tsc_pkg;

  typedef enum logic [2:0] {
    TSC_S_IDLE = 3'b001,
    TSC_S_SCAN = 3'b010,
    TSC_S_DONE = 3'b100
  } tsc_scan_type;

  // one buffered singles word with the link that delivered it
  typedef struct packed {
    logic [2:0]             link;
    logic [`TSC_WORD_W-1:0] word;
  } tsc_entry_type;

  typedef struct packed {
    logic [3:0] cnt;
    logic       marker;
    logic       long_mode;
    logic       bank;
  } tsc_gen_state_type;

  typedef struct packed {
    tsc_entry_type [`TSC_RAM_DEPTH-1:0] mem;
    tsc_entry_type                      rd_a;
    tsc_entry_type                      rd_b;
  } tsc_ram_state_type;

  typedef struct packed {
    logic                                     mode_m;
    logic                                     mode_s;
    logic [1:0]                               cfg_m;
    logic [1:0]                               cfg_s;
    logic                                     lclk_m;
    logic                                     lclk_s;
    logic                                     lclk_p;
    logic [`TSC_LINKS-1:0]                    lv_m;
    logic [`TSC_LINKS-1:0]                    lv_s;
    logic [`TSC_LINKS-1:0][`TSC_WORD_W-1:0]   lw_m;
    logic [`TSC_LINKS-1:0][`TSC_WORD_W-1:0]   lw_s;
    logic [`TSC_LINKS-1:0][2:0]               lim_cnt;
    logic [`TSC_LINKS-1:0]                    pend_v;
    logic [`TSC_LINKS-1:0][`TSC_WORD_W-1:0]   pend_w;
    logic [5:0]                               wr_ptr;
    logic [5:0]                               scan_n;
    tsc_scan_type                             scan_st;
    logic [4:0]                               si;
    logic [4:0]                               sj;
    logic                                     pv;
    logic [`TSC_PAIRS-1:0][4:0]               pair_cnt;
    logic                                     mk_d1;
    logic                                     slice_out;
    logic                                     coin_v;
    logic [`TSC_WORD_W-1:0]                   coin_a;
    logic [`TSC_WORD_W-1:0]                   coin_b;
    logic                                     coin_mk;
  } tsc_top_state_type;

endpackage : tsc_pkg

/* File: src/tsc_ifs.sv */
// interfaces between the slice generator, the slice buffer and the top module
// assumes tsc_pkg is compiled first
`timescale 1ns/1ps

interface tsc_slice_if;
  logic marker;
  logic long_mode;
  logic bank;
  modport gen  (output marker, output long_mode, output bank);
  modport user (input marker, input long_mode, input bank);
endinterface : tsc_slice_if

interface tsc_ram_if;
  logic                  we;
  logic [5:0]            waddr;
  tsc_pkg::tsc_entry_type wdata;
  logic [5:0]            raddr_a;
  logic [5:0]            raddr_b;
  tsc_pkg::tsc_entry_type rdata_a;
  tsc_pkg::tsc_entry_type rdata_b;
  modport ram  (input we, input waddr, input wdata, input raddr_a, input raddr_b,
                output rdata_a, output rdata_b);
  modport user (output we, output waddr, output wdata, output raddr_a, output raddr_b,
                input rdata_a, input rdata_b);
endinterface : tsc_ram_if

/* File: src/tsc_slice_gen.sv */
// slice boundary generator: one-clock marker every 8 or 16 clocks, plus bank toggle
// assumes long_req is already synchronised to clk
`timescale 1ns/1ps
`include "tsc_defs.svh"

module tsc_slice_gen (
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   long_req,
  tsc_slice_if.gen    sl
);

  tsc_pkg::tsc_gen_state_type s_q;
  tsc_pkg::tsc_gen_state_type s_d;
  logic                       last;

  // count within the slice; mode changes only at a slice boundary
  always_comb begin
    s_d    = s_q;
    last   = (s_q.cnt == (s_q.long_mode ? `TSC_LAST_LONG : `TSC_LAST_SHORT));
    s_d.marker = (s_q.cnt == 4'h0);
    if (last) begin
      s_d.cnt       = 4'h0;
      s_d.long_mode = long_req;
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
    if (s_q.cnt == 4'h0) begin
      s_d.bank = ~s_q.bank;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sl.marker    = s_q.marker;
  assign sl.long_mode = s_q.long_mode;
  assign sl.bank      = s_q.bank;

endmodule : tsc_slice_gen

/* File: src/tsc_slice_ram.sv */
// two-bank slice buffer: one write port, two registered read ports
// assumes addresses are valid in the cycle before data is wanted
`timescale 1ns/1ps
`include "tsc_defs.svh"

module tsc_slice_ram (
  input  wire logic   clk,
  input  wire logic   rst_n,
  tsc_ram_if.ram      rp
);

  tsc_pkg::tsc_ram_state_type s_q;
  tsc_pkg::tsc_ram_state_type s_d;

  // write and read in the same cycle; read data come out of a register
  always_comb begin
    s_d      = s_q;
    s_d.rd_a = s_q.mem[rp.raddr_a];
    s_d.rd_b = s_q.mem[rp.raddr_b];
    if (rp.we) begin
      s_d.mem[rp.waddr] = rp.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rp.rdata_a = s_q.rd_a;
  assign rp.rdata_b = s_q.rd_b;

endmodule : tsc_slice_ram

/* File: src/tsc_top.sv */
// time-slice coincidence block: slice framing, per-link word limiting, same-slice pairing
// assumes link pins and mode/size pins are asynchronous to clk; link_clk is sampled, not used as a clock
//
// Summary of operation
// - one system clock drives all slice logic of the chain
// - marker rising edge marks first clock of a slice; processing aligns to it
// - short word mode: marker once every eight clocks
// - long word mode: marker once every sixteen clocks
// - short mode words carry half the bits of long mode words
// - every processing step completes inside one slice; longer work is pipelined
// - two singles pair only when both belong to the same slice
// - every singles output stage passes at most four words per slice
// - single-unit size: pairs from the same detector_board are never formed
// - mid size: pairs from the same detector_unit are rejected
// - large size: pairs through the same coincidence_unit slot are rejected
// - up to 32 singles per slice, four from each of eight links
// - up to 16 coincidences per slice for each of 28 link pairings
// - large size: slot carries up to eight units; mid size: exactly one
// - marker stays high for exactly one clock per period
// - each output stage forwards a marker copy aligned with its data
// - moving one singles word between stages takes one slice
`timescale 1ns/1ps
`include "tsc_defs.svh"

module tsc_top (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic                                   long_mode_req,
  input  wire logic [1:0]                             size_cfg,
  input  wire logic                                   link_clk,
  input  wire logic [`TSC_LINKS-1:0]                  link_valid,
  input  wire logic [`TSC_LINKS-1:0][`TSC_WORD_W-1:0] link_word,
  output logic                                        slice_marker,
  output logic                                        long_mode,
  output logic                                        coin_valid,
  output logic [`TSC_WORD_W-1:0]                      coin_word_a,
  output logic [`TSC_WORD_W-1:0]                      coin_word_b,
  output logic                                        coin_marker
);

  tsc_slice_if sl ();
  tsc_ram_if   rp ();

  tsc_pkg::tsc_top_state_type s_q;
  tsc_pkg::tsc_top_state_type s_d;

  logic                link_edge;
  logic                found;
  logic [2:0]          pick;
  logic [4:0]          pidx;
  logic                same_src;
  logic                same_link;
  logic [5:0]          n_last;
  tsc_pkg::tsc_entry_type ea;
  tsc_pkg::tsc_entry_type eb;

  // timing of one slice, clock by clock, counted from the internal marker
  //   m0: internal marker high, bank flips, counters and limits restart
  //   m0: the closed slice's word count is latched as the search length
  //   m0: pending words not yet written are dropped with the old slice
  //   m0: no write lands in this cycle, so no old word enters the new bank
  //   m1: slice_marker pin high, first pair addresses already on the buffer
  //   m2: first pair data out of the buffer registers, compared this cycle
  //   m3: first coincidence on the pins if the pair is allowed
  //   then one candidate pair per clock until the pairs run out
  //   or until the next marker, whichever comes first
  //
  // link path, counted from the link clock rising at its pin
  //   c0: pin rises, words and valids already standing
  //   c1: first synchroniser stage
  //   c2: second stage, edge seen against the previous sample
  //   c3: accepted words become pending, one per link
  //   c4 onward: one pending word written per clock, lowest link first
  //
  // hazards and limits a user must know
  //   a link with a word still pending ignores its next word
  //   the fifth word of a link within one slice is ignored
  //   words beyond the buffer's half are dropped for that slice
  //   pairs the search does not reach before the next marker are lost
  //   a long slice gives room for 15 candidates, a short one for 7
  //   size and mode pins are sampled through two flops each
  //   mode changes only where a slice ends, never inside one
  //
  // pairing policy per size setting
  //   single unit: reject when the board fields of both words agree
  //   mid size: reject when both words came in on one link
  //   large size: reject when both words came through one slot
  //   reserved: reject when the unit fields of both words agree
  //   pairs of one link pairing are capped per slice
  //   pairs within one link carry no pairing counter
  //
  // buffer use
  //   the write bank holds the slice being filled
  //   the other bank holds the slice being searched
  //   both read ports address the search bank
  //   read data arrive one clock after the address
  //
  // output stage
  //   every output but long_mode is taken from a register of this module; long_mode comes from the slice generator's
  //   the output marker copy trails the pin marker by one clock
  //   coincidence words hold until the next coincidence

  // slice framing shared by everything below
  tsc_slice_gen u_gen (
    .clk      (clk),
    .rst_n    (rst_n),
    .long_req (s_q.mode_s),
    .sl       (sl.gen)
  );

  // buffer holding the current slice (write bank) and the previous one (search bank)
  tsc_slice_ram u_ram (
    .clk   (clk),
    .rst_n (rst_n),
    .rp    (rp.ram)
  );

  // index of a link pairing, lo < hi, in 0..27
  function automatic logic [4:0] pair_index(input logic [2:0] a, input logic [2:0] b);
    logic [2:0] lo;
    logic [2:0] hi;
    logic [4:0] res;
    lo  = (a < b) ? a : b;
    hi  = (a < b) ? b : a;
    res = 5'h00;
    case ({lo, hi})
      6'h01:   res = 5'h00;
      6'h02:   res = 5'h01;
      6'h03:   res = 5'h02;
      6'h04:   res = 5'h03;
      6'h05:   res = 5'h04;
      6'h06:   res = 5'h05;
      6'h07:   res = 5'h06;
      6'h0a:   res = 5'h07;
      6'h0b:   res = 5'h08;
      6'h0c:   res = 5'h09;
      6'h0d:   res = 5'h0a;
      6'h0e:   res = 5'h0b;
      6'h0f:   res = 5'h0c;
      6'h13:   res = 5'h0d;
      6'h14:   res = 5'h0e;
      6'h15:   res = 5'h0f;
      6'h16:   res = 5'h10;
      6'h17:   res = 5'h11;
      6'h1c:   res = 5'h12;
      6'h1d:   res = 5'h13;
      6'h1e:   res = 5'h14;
      6'h1f:   res = 5'h15;
      6'h25:   res = 5'h16;
      6'h26:   res = 5'h17;
      6'h27:   res = 5'h18;
      6'h2e:   res = 5'h19;
      6'h2f:   res = 5'h1a;
      6'h37:   res = 5'h1b;
      default: res = 5'h00;                                  // same link: no counter used
    endcase
    return res;
  endfunction : pair_index

  // true when two entries share the source that the size setting forbids pairing
  function automatic logic same_source(input logic [1:0] cfg, input tsc_pkg::tsc_entry_type a,
                                       input tsc_pkg::tsc_entry_type b);
    logic res;
    res = 1'b0;
    case (cfg)
      `TSC_CFG_SINGLE: res = (a.word[`TSC_BOARD_LSB +: 3] == b.word[`TSC_BOARD_LSB +: 3]);
      `TSC_CFG_MID:    res = (a.link == b.link);
      `TSC_CFG_LARGE:  res = (a.link == b.link);
      default:         res = (a.word[`TSC_UNIT_LSB +: 3] == b.word[`TSC_UNIT_LSB +: 3]);
    endcase
    return res;
  endfunction : same_source

  // pin synchronisers, link clock edge detection, limiting, buffering, pairing
  always_comb begin
    s_d       = s_q;
    found     = 1'b0;
    pick      = 3'h0;
    ea        = rp.rdata_a;
    eb        = rp.rdata_b;
    pidx      = pair_index(ea.link, eb.link);
    same_src  = same_source(s_q.cfg_s, ea, eb);
    same_link = (ea.link == eb.link);
    n_last    = s_q.scan_n - 6'h1;

    // two flops on every pin from outside the clock domain
    s_d.mode_m = long_mode_req;
    s_d.mode_s = s_q.mode_m;
    s_d.cfg_m  = size_cfg;
    s_d.cfg_s  = s_q.cfg_m;
    s_d.lclk_m = link_clk;
    s_d.lclk_s = s_q.lclk_m;
    s_d.lclk_p = s_q.lclk_s;
    s_d.lv_m   = link_valid;
    s_d.lv_s   = s_q.lv_m;
    s_d.lw_m   = link_word;
    s_d.lw_s   = s_q.lw_m;
    link_edge  = s_q.lclk_s & ~s_q.lclk_p;

    // drain one pending word per clock into the write bank
    for (int k = 0; k < `TSC_LINKS; k++) begin
      if (s_q.pend_v[k] && !found) begin
        found = 1'b1;
        pick  = 3'(k);
      end
    end
    rp.we         = found && (s_q.wr_ptr < `TSC_SLICE_WORDS) && !sl.marker;
    rp.waddr      = {sl.bank, s_q.wr_ptr[4:0]};
    rp.wdata.link = pick;
    rp.wdata.word = s_q.pend_w[pick];
    if (rp.we) begin
      s_d.pend_v[pick] = 1'b0;
      s_d.wr_ptr       = s_q.wr_ptr + 6'h1;
    end

    // accept at most four words per link in this slice
    if (link_edge) begin
      for (int k = 0; k < `TSC_LINKS; k++) begin
        if (s_q.lv_s[k] && !s_q.pend_v[k] && (s_q.lim_cnt[k] < `TSC_WORDS_PER_LINK)) begin
          s_d.pend_v[k]  = 1'b1;
          s_d.pend_w[k]  = sl.long_mode ? s_q.lw_s[k] : (s_q.lw_s[k] & `TSC_SHORT_MASK);
          s_d.lim_cnt[k] = s_q.lim_cnt[k] + 3'h1;
        end
      end
    end

    // search the previous slice's bank, one candidate pair per clock
    rp.raddr_a = {~sl.bank, s_q.si};
    rp.raddr_b = {~sl.bank, s_q.sj};
    s_d.pv     = 1'b0;
    case (s_q.scan_st)
      tsc_pkg::TSC_S_IDLE: begin
        s_d.scan_st = tsc_pkg::TSC_S_IDLE;
      end
      tsc_pkg::TSC_S_SCAN: begin
        s_d.pv = 1'b1;
        if ({1'b0, s_q.sj} == n_last) begin
          if ({1'b0, s_q.si} == n_last - 6'h1) begin
            s_d.scan_st = tsc_pkg::TSC_S_DONE;
          end else begin
            s_d.si = s_q.si + 5'h1;
            s_d.sj = s_q.si + 5'h2;
          end
        end else begin
          s_d.sj = s_q.sj + 5'h1;
        end
      end
      tsc_pkg::TSC_S_DONE: begin
        s_d.scan_st = tsc_pkg::TSC_S_DONE;
      end
      default: begin
        s_d.scan_st = tsc_pkg::TSC_S_IDLE;
      end
    endcase

    // compare the pair read last clock and emit a coincidence
    s_d.coin_v = 1'b0;
    if (s_q.pv && !same_src && (same_link || (s_q.pair_cnt[pidx] < `TSC_PAIR_LIMIT))) begin
      s_d.coin_v         = 1'b1;
      s_d.coin_a         = ea.word;
      s_d.coin_b         = eb.word;
      if (!same_link) begin
        s_d.pair_cnt[pidx] = s_q.pair_cnt[pidx] + 5'h1;
      end
    end

    // marker copy delayed to line up with the coincidence output stage
    s_d.mk_d1     = sl.marker;
    s_d.coin_mk   = s_q.mk_d1;
    s_d.slice_out = sl.marker;

    // slice boundary: swap banks, restart limits and start the search of the closed slice
    if (sl.marker) begin
      s_d.lim_cnt  = '0;
      s_d.pend_v   = '0;
      s_d.wr_ptr   = 6'h0;
      s_d.pair_cnt = '0;
      s_d.pv       = 1'b0;
      s_d.scan_n   = s_q.wr_ptr;
      s_d.si       = 5'h0;
      s_d.sj       = 5'h1;
      if (s_q.wr_ptr >= 6'h2) begin
        s_d.scan_st = tsc_pkg::TSC_S_SCAN;
      end else begin
        s_d.scan_st = tsc_pkg::TSC_S_IDLE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.scan_st <= tsc_pkg::TSC_S_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // all outputs straight from flip-flops
  assign slice_marker = s_q.slice_out;
  assign long_mode    = sl.long_mode;
  assign coin_valid   = s_q.coin_v;
  assign coin_word_a  = s_q.coin_a;
  assign coin_word_b  = s_q.coin_b;
  assign coin_marker  = s_q.coin_mk;

endmodule : tsc_top

/* File: verif/tsc_top_asserts.sv */
// checker for tsc_top: slice marker framing and coincidence output relations
// assumes it is bound to tsc_top and sees only its ports
`timescale 1ns/1ps

module tsc_top_asserts (
  input logic        clk,
  input logic        rst_n,
  input logic [1:0]  size_cfg,
  input logic        slice_marker,
  input logic        long_mode,
  input logic        coin_valid,
  input logic [31:0] coin_word_a,
  input logic [31:0] coin_word_b,
  input logic        coin_marker
);
  // one clock domain, reset disables every check
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // marker framing
  a_marker_width: assert property (slice_marker |=> !slice_marker)
    else $error("slice marker wider than one clock");
  a_min_period: assert property (slice_marker |=> !slice_marker [*7])
    else $error("slice marker repeats too early");
  a_short_period: assert property (slice_marker ##1 !long_mode |-> !slice_marker [*7] ##1 slice_marker)
    else $error("short slice not eight clocks");
  a_long_period: assert property (slice_marker ##1 long_mode |-> !slice_marker [*7] ##9 slice_marker)
    else $error("long slice not sixteen clocks");
  a_first_marker: assert property ($rose(rst_n) |-> ##1 !slice_marker ##1 slice_marker)
    else $error("first marker late after reset");
  a_mode_bound: assert property ($changed(long_mode) |-> ##[0:2] slice_marker)
    else $error("mode changed away from a slice boundary");
  // output stage relations
  a_coin_marker: assert property (1'b1 |=> coin_marker == $past(slice_marker))
    else $error("output marker copy misaligned");
  a_board_split: assert property (coin_valid && size_cfg == 2'h0 |-> coin_word_a[2:0] != coin_word_b[2:0])
    else $error("pair from one detector board");

  // main scenarios reached
  c_long_slice: cover property (slice_marker ##1 long_mode);
  c_coin: cover property (coin_valid);
  c_two_coins: cover property (coin_valid ##[1:4] coin_valid);
endmodule : tsc_top_asserts

bind tsc_top tsc_top_asserts u_chk (
  .clk          (clk),
  .rst_n        (rst_n),
  .size_cfg     (size_cfg),
  .slice_marker (slice_marker),
  .long_mode    (long_mode),
  .coin_valid   (coin_valid),
  .coin_word_a  (coin_word_a),
  .coin_word_b  (coin_word_b),
  .coin_marker  (coin_marker)
);

/* File: verif/tsc_link_src.sv */
// link-side source model: frames singles words onto the eight link inputs
// assumes the caller times frames; the link clock stands still between frames
`timescale 1ns/1ps

module tsc_link_src (
  output logic             link_clk,
  output logic [7:0]       link_valid,
  output logic [7:0][31:0] link_word
);
  // idle lines at time zero
  initial begin
    link_clk   = 1'b0;
    link_valid = 8'h00;
    link_word  = '0;
  end

  // one link clock period, at most one word per link per frame
  task automatic send(input logic [7:0] v, input logic [7:0][31:0] w);
    link_valid = v;
    link_word  = w;
    link_clk   = 1'b1;
    #100;
    link_clk = 1'b0;
    #100;
  endtask : send

  // release: no valid, words inverted so no stale value shows
  task automatic idle();
    link_valid = 8'h00;
    link_word  = ~link_word;
  endtask : idle
endmodule : tsc_link_src

/* File: verif/testbench.sv */
// self-checking bench for tsc_top: marker periods, reset, pairing per size setting
// assumes tsc_link_src drives the link pins and the checker is bound
`timescale 1ns/1ps

module testbench;
  logic             clk;
  logic             rst_n = 1'b0;
  logic             long_mode_req = 1'b0;
  logic [1:0]       size_cfg = 2'h0;
  logic             link_clk;
  logic [7:0]       link_valid;
  logic [7:0][31:0] link_word;
  logic             slice_marker;
  logic             long_mode;
  logic             coin_valid;
  logic [31:0]      coin_word_a;
  logic [31:0]      coin_word_b;
  logic             coin_marker;
  int               failures;
  int               total_checks;
  logic [31:0]      ca[$];
  logic [31:0]      cb[$];

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  tsc_top dut (
    .clk(clk), .rst_n(rst_n), .long_mode_req(long_mode_req), .size_cfg(size_cfg),
    .link_clk(link_clk), .link_valid(link_valid), .link_word(link_word),
    .slice_marker(slice_marker), .long_mode(long_mode), .coin_valid(coin_valid),
    .coin_word_a(coin_word_a), .coin_word_b(coin_word_b), .coin_marker(coin_marker)
  );

  tsc_link_src u_src (.link_clk(link_clk), .link_valid(link_valid), .link_word(link_word));

  // capture every coincidence where outputs are settled
  always @(negedge clk) begin
    if (coin_valid === 1'b1) begin
      ca.push_back(coin_word_a);
      cb.push_back(coin_word_b);
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // wait for a marker, bounded
  task automatic wait_mark();
    int k;
    k = 0;
    while (slice_marker !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_mark

  // clocks from one marker to the next
  task automatic gap(output int n);
    wait_mark();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (slice_marker !== 1'b1 && n < 40);
  endtask : gap

  task automatic t_reset();
    int n;
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(slice_marker, 1'b0, "marker in first clock");
    @(negedge clk);
    check(slice_marker, 1'b1, "first marker");
    check(long_mode, 1'b0, "mode after reset");
    gap(n);
    check(n, 8, "period after reset");
    $display("reset test done");
  endtask : t_reset

  task automatic t_mode(input logic m, input int per);
    int n;
    int k;
    long_mode_req = m;
    k = 0;
    while (long_mode !== m && k < 100) begin
      @(negedge clk);
      k++;
    end
    gap(n);
    gap(n);
    check(long_mode, m, "mode in force");
    check(n, per, "slice period");
    $display("mode test %0d done", m);
  endtask : t_mode

  // three words, two slots alike in link, two alike in board
  task automatic t_pair(input logic [1:0] cfg);
    logic [31:0] eb;
    size_cfg = cfg;
    eb = (cfg == 2'h0) ? 32'h0000c102 : 32'h0000b101;
    repeat (8) @(negedge clk);
    ca.delete();
    cb.delete();
    wait_mark();
    u_src.send(8'h03, {192'h0, 32'h0000b101, 32'h0000a101});
    u_src.send(8'h01, {224'h0, 32'h0000c102});
    u_src.idle();
    repeat (40) @(negedge clk);
    check(32'(ca.size()), 32'h2, "pair count");
    check(ca[0], 32'h0000a101, "first a");
    check(cb[0], eb, "first b");
    check(ca[1], 32'h0000b101, "second a");
    check(cb[1], 32'h0000c102, "second b");
    $display("pair test cfg %0d done", cfg);
  endtask : t_pair

  // short words lose the upper half; words of different slices never pair
  task automatic t_short();
    size_cfg = 2'h0;
    ca.delete();
    cb.delete();
    wait_mark();
    u_src.send(8'h03, {192'h0, 32'h00000102, 32'hffff0001});
    u_src.send(8'h01, {224'h0, 32'h00000103});
    u_src.send(8'h02, {192'h0, 32'h00000104, 32'h0});
    u_src.idle();
    repeat (40) @(negedge clk);
    check(32'(ca.size()), 32'h1, "cross slice count");
    check(ca[0], 32'h00000001, "short a");
    check(cb[0], 32'h00000102, "short b");
    $display("short test done");
  endtask : t_short

  // main sequence, with a second reset at the end of the run
  initial begin
    t_reset();
    t_mode(1'b1, 16);
    t_pair(2'h0);
    t_pair(2'h1);
    t_pair(2'h2);
    t_mode(1'b0, 8);
    t_short();
    t_reset();
    conclude();
  end

  // watchdog well beyond the expected run
  initial begin
    #200000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule : testbench
